// ===== common/sbc_pkg.sv
// Shared constants, widths and burst address arithmetic for the burst cache SRAM.
package sbc_pkg;

	// ==========================================================
	// Array geometry.
	localparam int ADDR_W = 18;
	localparam int DATA_W = 16;
	localparam int PAR_W = 2;
	localparam int BYTE_W = 8;
	localparam int LANE_W = 9;
	localparam int LANES = 2;
	localparam int WORD_W = 18;
	localparam int DEPTH = 262144;
	localparam int BURST_W = 2;

	// ==========================================================
	// Burst order encoding of the mode pin.
	localparam logic MODE_LINEAR = 1'h0;
	localparam logic MODE_INTERLEAVE = 1'h1;
	localparam logic MODE_RESET = MODE_INTERLEAVE;

	// ==========================================================
	// Byte lane masks and burst constants.
	localparam logic [1:0] LANES_ALL = 2'h3;
	localparam logic [1:0] LANES_NONE = 2'h0;
	localparam logic [1:0] STEP_FIRST = 2'h0;
	localparam logic [1:0] STEP_ONE = 2'h1;

	// ==========================================================
	// Timing: clock period and sleep entry and recovery in cycles.
	localparam int CLK_PERIOD_NS = 5;
	localparam int SLEEP_ENTRY_CYC = 2;
	localparam int SLEEP_RECOVERY_CYC = 2;

	// Low burst address bits for a given start value and beat number.
	function automatic logic [1:0] sbc_burst_addr(
		input logic [1:0] start,
		input logic [1:0] step,
		input logic mode
	);
		if (mode == MODE_INTERLEAVE) begin
			sbc_burst_addr = start ^ step;
		end else begin
			sbc_burst_addr = start + step;
		end
	endfunction : sbc_burst_addr

endpackage : sbc_pkg

// ===== src/sbc_burst_counter.sv
// Two-bit wrap-around burst counter with linear or interleaved order.
`timescale 1ns/100ps
module sbc_burst_counter (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic load,
	input wire logic [1:0] load_val,
	input wire logic advance,
	input wire logic mode,
	output logic [1:0] cur_lo,
	output logic [1:0] nxt_lo
);

	// ==========================================================
	// Start value and beat number.
	logic [1:0] start_ff;
	logic [1:0] step_ff;
	logic [1:0] nxt_step;

	// The step wraps in two bits, so a fifth beat returns to the start.
	assign nxt_step = step_ff + sbc_pkg::STEP_ONE;

	// A load restarts the sequence; advance moves one beat on.
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			start_ff <= sbc_pkg::STEP_FIRST;
			step_ff <= sbc_pkg::STEP_FIRST;
		end else if (load) begin
			start_ff <= load_val;
			step_ff <= sbc_pkg::STEP_FIRST;
		end else if (advance) begin
			step_ff <= nxt_step;
		end
	end

	// Current and following burst address, both from one shared function.
	assign cur_lo = sbc_pkg::sbc_burst_addr(start_ff, step_ff, mode);
	assign nxt_lo = sbc_pkg::sbc_burst_addr(start_ff, nxt_step, mode);

endmodule : sbc_burst_counter

// ===== src/sbc_cache_sram.sv
// Synchronous pipelined burst cache SRAM, 256K x 18, common data I/O.
`timescale 1ns/100ps
module sbc_cache_sram (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic [17:0] addr,
	input wire logic processor_addr_strobe_n,
	input wire logic controller_addr_strobe_n,
	input wire logic burst_advance_n,
	input wire logic byte_write_enable_n,
	input wire logic [1:0] byte_lane_select_n,
	input wire logic global_write_n,
	input wire logic chip_sel_low_a_n,
	input wire logic chip_sel_high,
	input wire logic chip_sel_low_b_n,
	input wire logic output_enable_n,
	input wire logic sleep_request,
	input wire logic burst_mode,
	input wire logic [15:0] data_in,
	input wire logic [1:0] parity_lines_in,
	output logic [15:0] data_out,
	output logic [1:0] parity_lines_out,
	output logic data_oe_n,
	output logic sleep_status
);

	// ==========================================================
	// Storage and pipeline state.

	// The array itself; contents survive sleep and are never reset.
	logic [sbc_pkg::WORD_W-1:0] mem_q [0:sbc_pkg::DEPTH-1];

	logic [15:0] data_out_ff;
	logic [1:0] parity_out_ff;
	logic drive_ff;
	logic [17:0] acc_addr_ff;
	logic acc_rd_ff;
	logic acc_any_ff;
	logic active_ff;
	logic [17:2] base_hi_ff;
	logic zz_s1_ff;
	logic zz_s2_ff;
	logic mode_s1_ff;
	logic mode_s2_ff;

	// ==========================================================
	// Asynchronous pin synchronisers.

	// Sleep request and mode are asynchronous pins; two flops each.
	// The second stage of the sleep chain is also the two-cycle entry
	// and exit delay, so no further counting is needed.
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			zz_s1_ff <= 1'h0;
			zz_s2_ff <= 1'h0;
		end else begin
			zz_s1_ff <= sleep_request;
			zz_s2_ff <= zz_s1_ff;
		end
	end

	// Mode resets to interleaved; after reset both flops follow the pin.
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			mode_s1_ff <= sbc_pkg::MODE_RESET;
			mode_s2_ff <= sbc_pkg::MODE_RESET;
		end else begin
			mode_s1_ff <= burst_mode;
			mode_s2_ff <= mode_s1_ff;
		end
	end

	logic asleep;
	assign asleep = zz_s2_ff;

	// ==========================================================
	// Cycle decode.

	logic selected;
	logic processor_addr_strobe_eff;
	logic controller_addr_strobe_eff;
	logic start_p;
	logic start_c;
	logic start_any;
	logic deselect;
	logic cont;
	logic write_req;
	logic [1:0] lane_en;

	// All three selects must be active; the middle one is active high.
	assign selected = !chip_sel_low_a_n && chip_sel_high && !chip_sel_low_b_n;

	// Processor strobe only counts while the first select is low.
	assign processor_addr_strobe_eff = !processor_addr_strobe_n && !chip_sel_low_a_n;

	// Controller strobe loses to an effective processor strobe.
	assign controller_addr_strobe_eff = !controller_addr_strobe_n && !processor_addr_strobe_eff;

	// Starts and deselects; nothing is decoded while asleep.
	assign start_p = !asleep && selected && processor_addr_strobe_eff;
	assign start_c = !asleep && selected && controller_addr_strobe_eff;
	assign start_any = start_p || start_c;
	assign deselect = !asleep && (processor_addr_strobe_eff || controller_addr_strobe_eff) && !selected;

	// With no strobe, an open burst continues or is suspended.
	assign cont = !asleep && active_ff && !processor_addr_strobe_eff && !controller_addr_strobe_eff;

	// Global write overrides byte enable and lane selects.
	assign write_req = !global_write_n ||
		(!byte_write_enable_n && (byte_lane_select_n != sbc_pkg::LANES_ALL));

	always_comb begin
		if (!global_write_n) begin
			lane_en = sbc_pkg::LANES_ALL;
		end else if (!byte_write_enable_n) begin
			lane_en = ~byte_lane_select_n;
		end else begin
			lane_en = sbc_pkg::LANES_NONE;
		end
	end

	// ==========================================================
	// Burst counter and effective address.

	logic [1:0] cur_lo;
	logic [1:0] nxt_lo;
	logic advance;
	logic [17:0] eff_addr;

	assign advance = cont && !burst_advance_n;

	sbc_burst_counter u_burst (
		.clk(clk),
		.arst_n(arst_n),
		.load(start_any),
		.load_val(addr[1:0]),
		.advance(advance),
		.mode(mode_s2_ff),
		.cur_lo(cur_lo),
		.nxt_lo(nxt_lo)
	);

	// A start uses the pins; a continue uses the next beat; a suspend
	// stays on the current beat.
	always_comb begin
		if (start_any) begin
			eff_addr = addr;
		end else if (advance) begin
			eff_addr = {base_hi_ff, nxt_lo};
		end else begin
			eff_addr = {base_hi_ff, cur_lo};
		end
	end

	// Upper address bits stay fixed for the whole burst.
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			base_hi_ff <= '0;
		end else if (start_any) begin
			base_hi_ff <= addr[17:2];
		end
	end

	// ==========================================================
	// Access kind for this cycle.

	logic wr_en;
	logic rd_en;

	// Write controls are ignored in the first cycle of a processor strobe
	// access, so that access is always a read.
	assign wr_en = (start_c || cont) && write_req;
	assign rd_en = start_p || ((start_c || cont) && !write_req);

	// A burst stays open until a deselect or sleep; pending work is dropped
	// on sleep entry rather than completed.
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			active_ff <= 1'h0;
		end else if (asleep || deselect) begin
			active_ff <= 1'h0;
		end else if (start_any) begin
			active_ff <= 1'h1;
		end
	end

	// Registered access: address and read flag for the output stage.
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			acc_addr_ff <= '0;
			acc_rd_ff <= 1'h0;
			acc_any_ff <= 1'h0;
		end else begin
			acc_rd_ff <= rd_en;
			acc_any_ff <= rd_en || wr_en;
			if (rd_en || wr_en) begin
				acc_addr_ff <= eff_addr;
			end
		end
	end

	// ==========================================================
	// Array write.

	// Each lane is nine bits: the byte plus its parity bit.
	always_ff @(posedge clk) begin
		if (wr_en) begin
			for (int l = 0; l < sbc_pkg::LANES; l++) begin
				if (lane_en[l]) begin
					mem_q[eff_addr][l*sbc_pkg::LANE_W +: sbc_pkg::LANE_W] <=
						{parity_lines_in[l], data_in[l*sbc_pkg::BYTE_W +: sbc_pkg::BYTE_W]};
				end
			end
		end
	end

	// ==========================================================
	// Read pipeline and output drivers.

	logic [sbc_pkg::WORD_W-1:0] rd_word;
	assign rd_word = mem_q[acc_addr_ff];

	// Data registered one cycle after the address, so the location seen is
	// the one addressed at the previous edge.
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			data_out_ff <= '0;
			parity_out_ff <= '0;
		end else if (acc_rd_ff) begin
			for (int l = 0; l < sbc_pkg::LANES; l++) begin
				data_out_ff[l*sbc_pkg::BYTE_W +: sbc_pkg::BYTE_W] <=
					rd_word[l*sbc_pkg::LANE_W +: sbc_pkg::BYTE_W];
				parity_out_ff[l] <= rd_word[l*sbc_pkg::LANE_W + sbc_pkg::BYTE_W];
			end
		end
	end

	// Drivers turn on for read data and off as soon as a write or sleep
	// is seen; this protects the shared pins even if output enable is low.
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			drive_ff <= 1'h0;
		end else if (wr_en || asleep) begin
			drive_ff <= 1'h0;
		end else begin
			drive_ff <= acc_rd_ff;
		end
	end

	// Output enable is not sampled: it gates the drive flag directly,
	// trading a purely registered enable for immediate release.
	assign data_oe_n = output_enable_n || !drive_ff;
	assign data_out = data_out_ff;
	assign parity_lines_out = parity_out_ff;
	assign sleep_status = zz_s2_ff;

	// ==========================================================
	// Assertions.

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!arst_n);

	sequence s_begin(logic m);
		start_any && !write_req && mode_s2_ff == m;
	endsequence

	sequence s_beat;
		advance && !write_req;
	endsequence

	a_ce1_gates_processor_addr_strobe: assert property (
		chip_sel_low_a_n && controller_addr_strobe_n && active_ff && !asleep |-> cont
	) else $error("processor strobe taken with first select high");

	a_start_read: assert property (
		start_p |=> acc_rd_ff && acc_addr_ff == $past(addr)
	) else $error("strobe start did not register a read");

	a_processor_addr_strobe_no_write: assert property (
		start_p |-> !wr_en
	) else $error("write taken in first processor strobe cycle");

	a_controller_addr_strobe_write: assert property (
		start_c && write_req |-> wr_en && eff_addr == addr
	) else $error("controller strobe write not taken at pin address");

	a_write_float: assert property (
		wr_en |=> data_oe_n
	) else $error("drivers still on after a write");

	a_oe_gate: assert property (
		output_enable_n |-> data_oe_n
	) else $error("drivers on while output enable is high");

	a_global_lanes: assert property (
		wr_en && !global_write_n |-> lane_en == sbc_pkg::LANES_ALL
	) else $error("global write did not enable every lane");

	a_burst_hold: assert property (
		acc_any_ff && cont && burst_advance_n |-> eff_addr == acc_addr_ff
	) else $error("suspended burst moved its address");

	a_linear_step: assert property (
		s_begin(sbc_pkg::MODE_LINEAR) ##1 s_beat |->
			eff_addr[1:0] == $past(eff_addr[1:0]) + 2'h1
	) else $error("linear burst did not add one");

	a_interleave_two: assert property (
		s_begin(sbc_pkg::MODE_INTERLEAVE) ##1 s_beat ##1 s_beat |->
			eff_addr[1:0] == ($past(eff_addr[1:0], 2) ^ 2'h2)
	) else $error("interleaved third beat wrong");

	a_read_latency: assert property (
		rd_en && !asleep ##1 !wr_en && !asleep |=> drive_ff
	) else $error("read data not driven one cycle after address");

	a_sleep_drop: assert property (
		asleep |=> !active_ff && !acc_any_ff && !drive_ff
	) else $error("access survived sleep entry");

	a_sleep_entry: assert property (
		sleep_request [*2] |=> sleep_status
	) else $error("sleep not entered within two cycles");

endmodule : sbc_cache_sram

// ===== verification/sbc_far_model.sv
// Far-side model of the processor or cache controller that drives the access pins.
`timescale 1ns/100ps
module sbc_far_model (
	input wire logic clk,
	output logic [17:0] addr,
	output logic processor_addr_strobe_n,
	output logic controller_addr_strobe_n,
	output logic burst_advance_n,
	output logic byte_write_enable_n,
	output logic [1:0] byte_lane_select_n,
	output logic global_write_n,
	output logic chip_sel_low_a_n,
	output logic chip_sel_high,
	output logic chip_sel_low_b_n,
	output logic output_enable_n,
	output logic sleep_request,
	output logic burst_mode,
	output logic [15:0] data_in,
	output logic [1:0] parity_lines_in
);
	// ==========================================================
	// Pin drive.
	// Start deselected and quiet, with the device's drivers held off.
	initial begin
		{processor_addr_strobe_n, controller_addr_strobe_n, burst_advance_n} = 3'h7;
		{byte_write_enable_n, byte_lane_select_n, global_write_n} = 4'hF;
		{chip_sel_low_a_n, chip_sel_high, chip_sel_low_b_n} = 3'h5;
		{output_enable_n, sleep_request, burst_mode} = 3'h5;
		{addr, parity_lines_in, data_in} = 36'h0_0000_0000;
	end

	// One clock of drive, changed at the falling edge and held through the next rise.
	// Write data shows only on a write; otherwise the lines flip, so stale data never
	// passes for a value the device captured by mistake.
	task automatic cyc(input logic [2:0] sel, input logic [17:0] a, input logic ps_n,
		input logic cs_n, input logic adv_n, input logic gw_n, input logic [2:0] bw_n,
		input logic [17:0] w);
		@(negedge clk);
		{chip_sel_low_a_n, chip_sel_high, chip_sel_low_b_n} = sel;
		{processor_addr_strobe_n, controller_addr_strobe_n} = {ps_n, cs_n};
		burst_advance_n = adv_n;
		{byte_write_enable_n, byte_lane_select_n, global_write_n} = {bw_n, gw_n};
		addr = a;
		if (!gw_n || (!bw_n[2] && bw_n[1:0] != 2'h3)) begin
			{parity_lines_in, data_in} = w;
		end else begin
			{parity_lines_in, data_in} = ~{parity_lines_in, data_in};
		end
	endtask : cyc

	// Read opened by the controller strobe; the write controls stay idle in that cycle.
	task automatic ctl_read(input logic [17:0] a);
		cyc(3'h2, a, 1'b1, 1'b0, 1'b1, 1'b1, 3'h7, 18'h0_0000);
	endtask : ctl_read

	// Output enable pin, set to the given level at the next falling edge and held there.
	task automatic set_oe(input logic v);
		@(negedge clk);
		output_enable_n = v;
	endtask : set_oe

	// Burst order pin.
	task automatic set_mode(input logic m);
		@(negedge clk);
		burst_mode = m;
	endtask : set_mode

	// Entry first closes any open burst with a strobe while deselected; around exit no
	// strobe or select is raised, so recovery stays idle.
	task automatic snooze(input logic on);
		cyc(3'h5, addr, 1'b1, !on, 1'b1, 1'b1, 3'h7, 18'h0_0000);
		@(negedge clk);
		sleep_request = on;
		if (!on) begin
			repeat (sbc_pkg::SLEEP_RECOVERY_CYC) begin
				cyc(3'h5, addr, 1'b1, 1'b1, 1'b1, 1'b1, 3'h7, 18'h0_0000);
			end
		end
	endtask : snooze
endmodule : sbc_far_model

// ===== verification/sbc_cache_sram_test.sv
// Self-checking testbench for the burst cache SRAM.
`timescale 1ns/100ps
module sbc_cache_sram_test;
	logic clk, arst_n;
	logic [17:0] addr;
	logic [15:0] data_in, data_out;
	logic [1:0] byte_lane_select_n, parity_lines_in, parity_lines_out;
	logic processor_addr_strobe_n, controller_addr_strobe_n, burst_advance_n;
	logic byte_write_enable_n, global_write_n, chip_sel_low_a_n, chip_sel_high;
	logic chip_sel_low_b_n, output_enable_n, sleep_request, burst_mode;
	logic data_oe_n, sleep_status;
	int bad_count, num_checks;

	// ==========================================================
	// Instances.
	sbc_far_model sbc_far_model_i (.clk, .addr, .processor_addr_strobe_n,
		.controller_addr_strobe_n, .burst_advance_n, .byte_write_enable_n,
		.byte_lane_select_n, .global_write_n, .chip_sel_low_a_n, .chip_sel_high,
		.chip_sel_low_b_n, .output_enable_n, .sleep_request, .burst_mode, .data_in,
		.parity_lines_in);
	sbc_cache_sram sbc_cache_sram_i (.clk, .arst_n, .addr, .processor_addr_strobe_n,
		.controller_addr_strobe_n, .burst_advance_n, .byte_write_enable_n,
		.byte_lane_select_n, .global_write_n, .chip_sel_low_a_n, .chip_sel_high,
		.chip_sel_low_b_n, .output_enable_n, .sleep_request, .burst_mode, .data_in,
		.parity_lines_in, .data_out, .parity_lines_out, .data_oe_n, .sleep_status);

	// Free-running clock.
	initial begin
		clk = 1'b0;
		forever #(sbc_pkg::CLK_PERIOD_NS / 2.0) clk = ~clk;
	end

	// ==========================================================
	// Helpers.
	task automatic check(input logic [17:0] seen, input logic [17:0] exp);
		num_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : check

	function automatic logic [17:0] word();
		return {parity_lines_out, data_out};
	endfunction : word

	// A distinct pattern per address, so a wrong beat never matches by luck.
	function automatic logic [17:0] pat(input logic [17:0] a);
		return a ^ 18'h2_5A5A;
	endfunction : pat

	// Expected word of beat k of a burst over rows 0x100 to 0x103 that starts at s.
	function automatic logic [17:0] bexp(input int s, input int k, input logic m);
		logic [1:0] lo;
		lo = m ? 2'(s ^ k) : 2'(s + k);
		return pat(18'h0_0100 | 18'(lo));
	endfunction : bexp

	task automatic nop(input logic adv_n);
		sbc_far_model_i.cyc(3'h2, 18'h0_0000, 1'b1, 1'b1, adv_n, 1'b1, 3'h7, 18'h0_0000);
	endtask : nop

	task automatic wr(input logic [17:0] a, input logic [17:0] w);
		sbc_far_model_i.cyc(3'h2, a, 1'b1, 1'b0, 1'b1, 1'b0, 3'h7, w);
	endtask : wr

	// Read data is judged two cycles after the start, one after it was registered.
	task automatic rd_chk(input logic [17:0] a, input logic [17:0] e);
		sbc_far_model_i.cyc(3'h2, a, 1'b0, 1'b1, 1'b1, 1'b1, 3'h7, 18'h0_0000);
		nop(1'b1);
		nop(1'b1);
		check(word(), e);
	endtask : rd_chk

	// ==========================================================
	// Scenarios.
	// A write with output enable still low must float the drivers anyway.
	task automatic s_write_read();
		sbc_far_model_i.set_oe(1'b1);
		wr(18'h0_0040, pat(18'h0_0040));
		nop(1'b1);
		sbc_far_model_i.set_oe(1'b0);
		rd_chk(18'h0_0040, pat(18'h0_0040));
		check(18'(data_oe_n), 18'h0_0000);
		sbc_far_model_i.set_oe(1'b1);
		#1 check(18'(data_oe_n), 18'h0_0001);
		sbc_far_model_i.set_oe(1'b0);
		#1 check(18'(data_oe_n), 18'h0_0000);
		wr(18'h0_0044, pat(18'h0_0044));
		nop(1'b1);
		check(18'(data_oe_n), 18'h0_0001);
		sbc_far_model_i.set_oe(1'b1);
		sbc_far_model_i.ctl_read(18'h0_0044);
		nop(1'b1);
		nop(1'b1);
		check(word(), pat(18'h0_0044));
	endtask : s_write_read

	// Every start value in both orders, then a suspend and a wrap back to the start.
	task automatic s_burst();
		for (int i = 0; i < 4; i++) wr(18'h0_0100 | 18'(i), pat(18'h0_0100 | 18'(i)));
		for (int m = 0; m < 2; m++) begin
			sbc_far_model_i.set_mode(m[0]);
			repeat (3) nop(1'b1);
			for (int s = 0; s < 4; s++) begin
				sbc_far_model_i.cyc(3'h2, 18'h0_0100 | 18'(s), 1'b0, 1'b1, 1'b1, 1'b1, 3'h7,
					18'h0_0000);
				nop(1'b0);
				for (int i = 0; i < 5; i++) begin
					nop(i < 2 ? 1'b0 : 1'b1);
					check(word(), bexp(s, i < 4 ? i : 3, m[0]));
				end
				nop(1'b0);
				nop(1'b1);
				nop(1'b1);
				check(word(), pat(18'h0_0100 | 18'(s)));
			end
		end
	endtask : s_burst

	// Lane writes, non-writes and the global override, one table row each.
	task automatic s_bytes();
		logic [2:0] bw [5] = '{3'h2, 3'h1, 3'h4, 3'h3, 3'h2};
		logic [17:0] w [5] = '{18'h3_FFFF, 18'h3_FFFF, 18'h0_0000, 18'h0_0000, 18'h2_AAAA};
		logic [17:0] e [5] = '{18'h1_00FF, 18'h3_FFFF, 18'h3_FFFF, 18'h3_FFFF, 18'h2_AAAA};
		wr(18'h0_0400, 18'h0_0000);
		for (int i = 0; i < 5; i++) begin
			sbc_far_model_i.cyc(3'h2, 18'h0_0400, 1'b1, 1'b0, 1'b1, i == 4 ? 1'b0 : 1'b1,
				bw[i], w[i]);
			rd_chk(18'h0_0400, e[i]);
		end
	endtask : s_bytes

	// Write controls on the processor strobe edge are ignored, one cycle later they write.
	task automatic s_proc_write();
		wr(18'h0_0200, 18'h1_1111);
		sbc_far_model_i.cyc(3'h2, 18'h0_0200, 1'b0, 1'b1, 1'b1, 1'b0, 3'h7, 18'h2_2222);
		nop(1'b1);
		rd_chk(18'h0_0200, 18'h1_1111);
		sbc_far_model_i.cyc(3'h2, 18'h0_0200, 1'b0, 1'b1, 1'b1, 1'b1, 3'h7, 18'h0_0000);
		sbc_far_model_i.cyc(3'h2, 18'h0_0000, 1'b1, 1'b1, 1'b1, 1'b0, 3'h7, 18'h2_2222);
		rd_chk(18'h0_0200, 18'h2_2222);
	endtask : s_proc_write

	// Strobes that must not start an access leave the array alone; deselected ones also close the burst.
	task automatic s_select();
		wr(18'h0_0301, pat(18'h0_0301));
		wr(18'h0_0300, pat(18'h0_0300));
		rd_chk(18'h0_0300, pat(18'h0_0300));
		sbc_far_model_i.cyc(3'h6, 18'h0_0301, 1'b0, 1'b1, 1'b0, 1'b1, 3'h7, 18'h0_0000);
		nop(1'b1);
		nop(1'b1);
		check(word(), pat(18'h0_0301));
		sbc_far_model_i.cyc(3'h0, 18'h0_0301, 1'b1, 1'b0, 1'b1, 1'b0, 3'h7, 18'h0_0000);
		sbc_far_model_i.cyc(3'h3, 18'h0_0301, 1'b1, 1'b0, 1'b1, 1'b0, 3'h7, 18'h0_0000);
		sbc_far_model_i.cyc(3'h2, 18'h0_0301, 1'b0, 1'b0, 1'b1, 1'b0, 3'h7, 18'h0_0000);
		nop(1'b1);
		rd_chk(18'h0_0301, pat(18'h0_0301));
	endtask : s_select

	// Contents survive sleep; a write attempted while asleep is dropped.
	task automatic s_sleep();
		sbc_far_model_i.snooze(1'b1);
		@(negedge clk);
		check(18'(sleep_status), 18'h0_0000);
		@(negedge clk);
		check(18'(sleep_status), 18'h0_0001);
		wr(18'h0_0040, 18'h0_0000);
		sbc_far_model_i.snooze(1'b0);
		check(18'(sleep_status), 18'h0_0000);
		rd_chk(18'h0_0040, pat(18'h0_0040));
	endtask : s_sleep

	// ==========================================================
	// Run control.
	task automatic summarize();
		$display("checks %0d, mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : summarize

	// Watchdog: a hang counts as a mismatch and still reaches the report.
	initial begin
		repeat (20000) @(posedge clk);
		bad_count++;
		summarize();
	end

	initial begin
		bad_count = 0;
		num_checks = 0;
		arst_n = 1'b0;
		repeat (4) @(negedge clk);
		arst_n = 1'b1;
		s_write_read();
		s_burst();
		s_bytes();
		s_proc_write();
		s_select();
		s_sleep();
		summarize();
	end
endmodule : sbc_cache_sram_test
